/* common/sgio_pkg.sv */
/*
  Shared constants for the serial gateway I/O connection handler.
  Assumes a single 20 MHz system clock and a synchronous active-high reset.
*/
package sgio_pkg;
  // ************************************************************
  // Sizes and frame layout.
  // ************************************************************
  localparam int unsigned SGIO_BUF_MAX = 124;           // Internal receive buffer size in characters.
  localparam logic [7:0] SGIO_BUF_MAX_B = 8'h7C;        // Same size as a byte value.
  localparam logic [7:0] SGIO_CMD_OVH = 8'h02;          // Command overhead: record number and length.
  localparam logic [7:0] SGIO_RSP_OVH = 8'h03;          // Response overhead: record, status, length.
  localparam logic [7:0] SGIO_REC_INIT = 8'h00;         // Record counter initialized state.
  localparam logic [7:0] SGIO_REC_FIRST = 8'h01;        // First record counter value.
  localparam logic [7:0] SGIO_REC_LAST = 8'hFF;         // Last record counter value before wrap.
  localparam int unsigned SGIO_ST_OVF_BIT = 0;          // Status bit: message ended by overflow.
  localparam int unsigned SGIO_ST_PAR_BIT = 1;          // Status bit: parity error seen.
  localparam logic [1:0] SGIO_BAUD_AUTO = 2'h3;         // Extended bit-rate code for autobaud.
  localparam logic [15:0] SGIO_RATE_ZERO = 16'h0000;    // Packet rate of zero disables the timer.
  localparam int unsigned SGIO_TIMEOUT_MULT = 4;        // Inactivity timeout in packet-rate periods.
  // Connection timer tick: one millisecond, in cycles of the 50 ns clock.
  localparam int unsigned SGIO_CLK_NS = 50;
  localparam int unsigned SGIO_TICK_NS = 1000000;
  localparam int unsigned SGIO_TICK_CYC = SGIO_TICK_NS / SGIO_CLK_NS;
endpackage

/* hw/sgio_conn.sv */
/*
  I/O connection handler: polled, cyclic and change-of-state connections
  around a shared serial receive buffer and a serial transmit FIFO.
  Assumes the fieldbus side and serial side are logic on clk_sys.
*/
// Operation
// - Only polled commands produce serial output
// - Transmit only on changed record number
// - Answer poll after transmission finishes
// - Send through delimiter; pad if enabled
// - New message bumps counter, length, data
// - Overflow sets status bit
// - Status reports parity errors
// - Cyclic responds each timer expiry, reloads
// - Cyclic is response only, coexists
// - All responses share one buffer
// - Change-of-state also sends on message
// - Cyclic and change-of-state exclusive
// - Change-of-state triggering enabled on creation
// - Command size is transmit size plus two
// - Timed connections take zero command bytes
// - Response size is receive size plus three if padding, else message length plus three
// - Timer and timeout from packet rate
// - Autobaud follows detected network rate
// - Autobaud only via extended setting
// - Record counter 1..255, wraps skipping zero
// - Response bytes: record, status, length, data
// - Length zero means delimited transmission
// - Unbounded receive overflows at 124 bytes
module sgio_conn
  import sgio_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 32,
  parameter int unsigned TICK_CYC = SGIO_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Configuration.
  input wire logic [7:0] cfg_tx_size,
  input wire logic [7:0] cfg_rx_size,
  input wire logic [7:0] cfg_tx_delim,
  input wire logic [7:0] cfg_rx_delim,
  input wire logic cfg_pad_en,
  input wire logic [7:0] cfg_pad_char,
  input wire logic [15:0] expected_packet_rate,
  input wire logic [1:0] cfg_std_baud,
  input wire logic [1:0] cfg_ext_baud,
  input wire logic [1:0] net_baud_detect,
  input wire logic cyc_open,
  input wire logic change_of_state_connection,
  // Polled command bytes from the master.
  input wire logic cmd_valid,
  input wire logic cmd_first,
  input wire logic cmd_last,
  input wire logic [7:0] cmd_byte,
  output logic cmd_size_err,
  // Response bytes to the master.
  output logic rsp_valid,
  output logic rsp_last,
  output logic [7:0] rsp_byte,
  output logic [1:0] rsp_conn,
  input wire logic rsp_ready,
  // Serial transmit and receive character paths.
  output logic tx_valid,
  output logic [7:0] tx_char,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_parity_err,
  // Status.
  output logic conn_refused,
  output logic conn_timeout,
  output logic [1:0] baud_sel
);
  // ************************************************************
  // Checks and state.
  // ************************************************************
  initial begin
    if (TICK_CYC < 1 || TICK_CYC > 32'h00100000) begin
      $error("sgio_conn tick count must be at least one");
    end
  end
  typedef enum logic [1:0] {SGIO_IDLE, SGIO_CMD, SGIO_TXW, SGIO_RSP} sgio_ph_e;
  typedef struct packed {
    sgio_ph_e ph;            // Protocol phase.
    logic [7:0] last_rec;    // Record number of the previous command.
    logic [7:0] cmd_idx;     // Byte index within a command.
    logic [7:0] tx_len;      // Length byte of the command.
    logic tx_go;             // Current command is to be transmitted.
    logic tx_stop;           // Delimiter already pushed in delimited mode.
    logic [7:0] rec_cnt;     // Receive record counter.
    logic [7:0] status;      // Receive status byte.
    logic [7:0] rlen;        // Valid length of the published message.
    logic [7:0] wcnt;        // Characters collected for the next message.
    logic [7:0] ridx;        // Response byte index.
    logic [7:0] rsp_tot;     // Total response bytes.
    logic [1:0] conn;        // Connection being answered.
    logic pend_cos;          // Change-of-state trigger waiting.
    logic pend_tim;          // Timer expiry waiting.
    logic [19:0] tick;       // Millisecond prescaler.
    logic [15:0] tmr;        // Connection timer.
    logic [17:0] idle;       // Inactivity counter in ticks.
    logic timeout;           // Inactivity timeout seen.
    logic size_err;          // Last command had a wrong size.
    logic refused;           // Both timed connections requested.
    logic [1:0] baud;        // Selected bit rate.
    logic rvalid;            // Registered response strobe.
    logic rlast;             // Registered last-byte flag.
    logic [7:0] rbyte;       // Registered response byte.
  } sgio_st_s;
  sgio_st_s s_q;
  sgio_st_s s_d;
  logic [7:0] pub_q [SGIO_BUF_MAX];   // Published message seen by every connection.
  logic [7:0] wrk_q [SGIO_BUF_MAX];   // Message being collected from the serial line.
  logic [7:0] rx_lim;                 // Characters that end a message by overflow.
  logic msg_done;                     // A received message completes this cycle.
  logic msg_ovf;                      // That message ended by overflow.
  logic tick_en;                      // One-cycle millisecond enable.
  logic tmr_exp;                      // Connection timer expired.
  logic fifo_rdy;                     // Transmit FIFO accepts a character.
  logic push_tx;                      // Character pushed into the transmit FIFO.
  logic cos_on;                       // Change-of-state connection live.
  logic cyc_on;                       // Cyclic connection live.
  logic [7:0] data_byte;              // Character selected for the response.
  logic [7:0] ch_idx;                 // Character index within the response.

  // ************************************************************
  // Serial transmit FIFO.
  // ************************************************************
  sgio_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_data(cmd_byte),
    .in_valid(push_tx),
    .in_ready(fifo_rdy),
    .out_data(tx_char),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  // Limit is the configured size, or the whole buffer when zero or larger than the buffer.
  assign rx_lim = (cfg_rx_size == 8'h00 || cfg_rx_size > SGIO_BUF_MAX_B) ? SGIO_BUF_MAX_B : cfg_rx_size;
  assign msg_done = rx_valid && ((rx_char == cfg_rx_delim) || (s_q.wcnt + 8'h01 == rx_lim));
  assign msg_ovf = msg_done && (rx_char != cfg_rx_delim);
  assign tick_en = s_q.tick == 20'(TICK_CYC - 1);
  assign tmr_exp = tick_en && (expected_packet_rate != SGIO_RATE_ZERO) && (s_q.tmr == 16'h0001);
  assign cos_on = change_of_state_connection && !cyc_open;
  assign cyc_on = cyc_open && !change_of_state_connection;
  // Command characters go to the FIFO only during a changed-record poll.
  assign push_tx = (s_q.ph == SGIO_CMD) && cmd_valid && s_q.tx_go && !s_q.tx_stop && (s_q.cmd_idx >= SGIO_CMD_OVH)
    && (s_q.tx_len == 8'h00 || (s_q.cmd_idx - SGIO_CMD_OVH) < s_q.tx_len);
  assign ch_idx = s_q.ridx - SGIO_RSP_OVH;
  assign data_byte = (ch_idx < s_q.rlen) ? pub_q[ch_idx[6:0]] : cfg_pad_char;

  // ************************************************************
  // Receive buffers: collect, then publish on completion.
  // ************************************************************
  // Characters land in the working buffer; a completed message is copied whole.
  always_ff @(posedge clk_sys) begin
    if (rx_valid && s_q.wcnt < SGIO_BUF_MAX_B) begin
      wrk_q[s_q.wcnt[6:0]] <= rx_char;
    end
  end
  for (genvar i = 0; i < SGIO_BUF_MAX; i++) begin : g_pub
    // Publish each entry when the message completes.
    always_ff @(posedge clk_sys) begin
      if (msg_done) begin
        pub_q[i] <= (i == s_q.wcnt) ? rx_char : wrk_q[i];
      end
    end
  end

  // ************************************************************
  // Next-state logic.
  // ************************************************************
  // Fills the next state from the current state and the inputs.
  always_comb begin
    s_d = s_q;
    s_d.rvalid = s_q.rvalid && !rsp_ready;
    s_d.rlast = s_q.rlast && !rsp_ready;
    s_d.refused = change_of_state_connection && cyc_open;
    s_d.baud = (cfg_ext_baud == SGIO_BAUD_AUTO) ? net_baud_detect : cfg_ext_baud;
    if (cfg_ext_baud != SGIO_BAUD_AUTO && cfg_std_baud != cfg_ext_baud && cfg_std_baud != SGIO_BAUD_AUTO) begin
      s_d.baud = cfg_std_baud;
    end
    // Millisecond prescaler and connection timer.
    s_d.tick = tick_en ? 20'h00000 : s_q.tick + 20'h00001;
    if (tick_en) begin
      s_d.tmr = (s_q.tmr <= 16'h0001) ? expected_packet_rate : s_q.tmr - 16'h0001;
      s_d.idle = s_q.idle + 18'h00001;
    end
    if (tick_en && expected_packet_rate != SGIO_RATE_ZERO
        && s_q.idle >= 18'(SGIO_TIMEOUT_MULT) * {2'b00, expected_packet_rate}) begin
      s_d.timeout = 1'b1;
    end
    if (tmr_exp && (cos_on || cyc_on)) begin
      s_d.pend_tim = 1'b1;
    end
    // Receive accounting.
    if (rx_valid && rx_parity_err) begin
      s_d.status[SGIO_ST_PAR_BIT] = 1'b1;
    end
    if (msg_done) begin
      s_d.rec_cnt = (s_q.rec_cnt == SGIO_REC_LAST) ? SGIO_REC_FIRST : s_q.rec_cnt + 8'h01;
      s_d.rlen = s_q.wcnt + 8'h01;
      s_d.wcnt = 8'h00;
      s_d.status[SGIO_ST_OVF_BIT] = msg_ovf;
      s_d.status[SGIO_ST_PAR_BIT] = rx_parity_err || s_q.status[SGIO_ST_PAR_BIT];
      if (cos_on) begin
        s_d.pend_cos = 1'b1;
      end
    end else if (rx_valid) begin
      s_d.wcnt = s_q.wcnt + 8'h01;
    end
    unique case (s_q.ph)
      SGIO_IDLE: begin
        if (cmd_valid && cmd_first) begin
          s_d.ph = SGIO_CMD;
          s_d.cmd_idx = 8'h01;
          s_d.tx_go = cmd_byte != s_q.last_rec;
          s_d.last_rec = cmd_byte;
          s_d.tx_stop = 1'b0;
          s_d.idle = '0;
          s_d.timeout = 1'b0;
        end else if (s_q.pend_cos || s_q.pend_tim) begin
          s_d.ph = SGIO_RSP;
          s_d.conn = s_q.pend_cos ? 2'h2 : 2'h1;
          s_d.pend_cos = msg_done && cos_on;
          s_d.pend_tim = tmr_exp && (cos_on || cyc_on);
          s_d.ridx = 8'h00;
        end
      end
      SGIO_CMD: begin
        if (cmd_valid) begin
          if (s_q.cmd_idx == 8'h01) begin
            s_d.tx_len = cmd_byte;
          end
          if (push_tx && s_q.tx_len == 8'h00 && cmd_byte == cfg_tx_delim) begin
            s_d.tx_stop = 1'b1;
          end
          s_d.cmd_idx = s_q.cmd_idx + 8'h01;
          // Wait in place if the FIFO is full and the character must go.
          if (push_tx && !fifo_rdy) begin
            s_d.cmd_idx = s_q.cmd_idx;
            s_d.tx_stop = s_q.tx_stop;
          end else if (cmd_last) begin
            s_d.size_err = (s_q.cmd_idx + 8'h01) != (cfg_tx_size + SGIO_CMD_OVH);
            s_d.ph = SGIO_TXW;
          end
        end
      end
      SGIO_TXW: begin
        if (!tx_valid) begin
          s_d.ph = SGIO_RSP;
          s_d.conn = 2'h0;
          s_d.ridx = 8'h00;
        end
      end
      SGIO_RSP: begin
        if (rsp_ready || !s_q.rvalid) begin
          s_d.rvalid = 1'b1;
          unique case (s_q.ridx)
            8'h00: s_d.rbyte = s_q.rec_cnt;
            8'h01: s_d.rbyte = s_q.status;
            8'h02: s_d.rbyte = s_q.rlen;
            default: s_d.rbyte = data_byte;
          endcase
          s_d.rsp_tot = (cfg_pad_en && !s_q.status[SGIO_ST_OVF_BIT] && cfg_rx_size != 8'h00)
            ? cfg_rx_size + SGIO_RSP_OVH : s_q.rlen + SGIO_RSP_OVH;
          s_d.rlast = (s_q.ridx + 8'h01) == s_d.rsp_tot;
          s_d.ridx = s_q.ridx + 8'h01;
          if (s_d.rlast) begin
            s_d.ph = SGIO_IDLE;
          end
        end else begin
          s_d.rvalid = 1'b1;
          s_d.rlast = s_q.rlast;
        end
      end
    endcase
  end

  // ************************************************************
  // State register.
  // ************************************************************
  // Registers the whole state; reset leaves the stored record at zero.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.ph <= SGIO_IDLE;
      s_q.baud <= SGIO_BAUD_AUTO;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_valid = s_q.rvalid;
  assign rsp_last = s_q.rlast;
  assign rsp_byte = s_q.rbyte;
  assign rsp_conn = s_q.conn;
  assign cmd_size_err = s_q.size_err;
  assign conn_refused = s_q.refused;
  assign conn_timeout = s_q.timeout;
  assign baud_sel = s_q.baud;

  // ************************************************************
  // Assertions.
  // ************************************************************
  sequence rec_repeat_s;
    s_q.ph == SGIO_IDLE && cmd_valid && cmd_first && cmd_byte == s_q.last_rec;
  endsequence
  rec_skip_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rec_repeat_s |=> !s_q.tx_go) else $error("Unchanged record started a transmission.");
  tx_only_poll_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (s_q.ph == SGIO_IDLE || s_q.ph == SGIO_RSP) |-> !tx_valid) else $error("Serial output outside a poll.");
  rec_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    msg_done && s_q.rec_cnt == SGIO_REC_LAST |=> s_q.rec_cnt == SGIO_REC_FIRST) else $error("Record counter bad wrap.");
  rec_nonzero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    msg_done |=> s_q.rec_cnt != SGIO_REC_INIT && s_q.rlen == $past(s_q.wcnt) + 8'h01) else $error("Message not counted.");
  ovf_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    msg_ovf |=> s_q.status[SGIO_ST_OVF_BIT]) else $error("Overflow not flagged.");
  par_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rx_valid && rx_parity_err |=> s_q.status[SGIO_ST_PAR_BIT]) else $error("Parity error not flagged.");
  rsp_head_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_q.ph == SGIO_RSP && s_q.ridx == 8'h00 && !s_q.rvalid ##1 1'b1 |-> rsp_byte == $past(s_q.rec_cnt))
    else $error("Response byte zero is not the record counter.");
  cos_pend_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    msg_done && cos_on |=> s_q.pend_cos || s_q.ph == SGIO_RSP) else $error("Change-of-state trigger lost.");
  excl_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    change_of_state_connection && cyc_open |=> conn_refused) else $error("Both timed connections accepted.");
  resp_after_tx_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_q.ph == SGIO_TXW && !tx_valid |=> s_q.ph == SGIO_RSP) else $error("Poll not answered after transmit.");
endmodule

/* hw/sgio_fifo.sv */
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
module sgio_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  // Depth must be a power of two of at least two for pointer wrap.
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("sgio_fifo depth must be a power of two");
    end
  end
  logic [WIDTH-1:0] mem_q [DEPTH];   // Storage words.
  logic [AW:0] wr_q;                 // Write pointer with wrap bit.
  logic [AW:0] rd_q;                 // Read pointer with wrap bit.
  logic push;
  logic pop;
  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Pointers and storage advance on accepted pushes and pops.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        mem_q[wr_q[AW-1:0]] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

/* test/serial_gateway_io_connections_test.sv */
/*
  Self-checking bench for the I/O connection handler and its FIFO, seen through the handler.
  Assumes the master model; the serial transmitter's ready is driven here.
*/
module serial_gateway_io_connections_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sgio_pkg::*;
  localparam int unsigned TICK = 4; // Shortened timer tick.
  logic clk_sys, sys_rst, cfg_pad_en, slow, cyc_open, change_of_state_connection, rx_valid, rx_parity_err;
  logic [7:0] cfg_tx_size, cfg_rx_size, cfg_tx_delim, cfg_rx_delim, cfg_pad_char, rx_char;
  logic [15:0] expected_packet_rate;
  logic [1:0] cfg_std_baud, cfg_ext_baud, net_baud_detect, rsp_conn, baud_sel;
  logic cmd_valid, cmd_first, cmd_last, cmd_size_err, rsp_valid, rsp_last, rsp_ready;
  logic tx_valid, tx_ready, conn_refused, conn_timeout;
  logic [7:0] cmd_byte, rsp_byte, tx_char;
  logic [7:0] tx_q[$]; // Characters sent on the serial output.
  logic [7:0] exp[$]; // Expected response frame.
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0; // Free-running cycle count.
  int t0;
  sgio_conn #(.FIFO_DEPTH(32), .TICK_CYC(TICK)) sgio_conn_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_tx_size(cfg_tx_size), .cfg_rx_size(cfg_rx_size),
    .cfg_tx_delim(cfg_tx_delim), .cfg_rx_delim(cfg_rx_delim), .cfg_pad_en(cfg_pad_en),
    .cfg_pad_char(cfg_pad_char), .expected_packet_rate(expected_packet_rate), .cfg_std_baud(cfg_std_baud),
    .cfg_ext_baud(cfg_ext_baud), .net_baud_detect(net_baud_detect), .cyc_open(cyc_open),
    .change_of_state_connection(change_of_state_connection), .cmd_valid(cmd_valid),
    .cmd_first(cmd_first), .cmd_last(cmd_last), .cmd_byte(cmd_byte), .cmd_size_err(cmd_size_err),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_byte(rsp_byte), .rsp_conn(rsp_conn),
    .rsp_ready(rsp_ready), .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_char(rx_char), .rx_parity_err(rx_parity_err),
    .conn_refused(conn_refused), .conn_timeout(conn_timeout), .baud_sel(baud_sel));
  sgio_master sgio_master_i (.clk_sys(clk_sys), .slow(slow), .cmd_valid(cmd_valid),
    .cmd_first(cmd_first), .cmd_last(cmd_last), .cmd_byte(cmd_byte), .rsp_valid(rsp_valid),
    .rsp_last(rsp_last), .rsp_byte(rsp_byte), .rsp_conn(rsp_conn), .rsp_ready(rsp_ready));
  // ************************************************************
  // Clock, serial monitor, watchdog and shared tasks.
  // ************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Records every serial output character that the transmitter takes.
  always @(posedge clk_sys) begin
    cyc++;
    if (tx_valid && tx_ready) tx_q.push_back(tx_char);
  end
  // Cuts a hang short well beyond the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    print_verdict();
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // One received character, strobed for a single cycle.
  task automatic rx_send(input logic [7:0] c, input logic perr);
    @(posedge clk_sys);
    {rx_valid, rx_char, rx_parity_err} <= {1'b1, c, perr};
    @(posedge clk_sys);
    {rx_valid, rx_char, rx_parity_err} <= {1'b0, ~c, 1'b0};
  endtask
  // Waits for the next whole frame and compares it with exp.
  task automatic get_rsp(input string what, input logic [1:0] conn);
    int n;
    n = sgio_master_i.frames;
    for (int t = 0; t < 400 && sgio_master_i.frames == n; t++) @(negedge clk_sys);
    check({what, " frame"}, 8'h01, 8'(sgio_master_i.frames != n));
    check({what, " conn"}, {6'h0, conn}, {6'h0, sgio_master_i.conn_q});
    check({what, " size"}, 8'(exp.size()), 8'(sgio_master_i.rsp_q.size()));
    for (int i = 0; i < exp.size(); i++) check(what, exp[i], sgio_master_i.rsp_q[i]);
    $display("test %s done", what);
  endtask
  // Polled command of transmit size plus two; the length picks how much goes out.
  task automatic poll(input logic [7:0] rec, input logic [7:0] len, input logic [7:0] ntx, input string what);
    tx_q.delete();
    sgio_master_i.send_cmd({rec, len, 8'h58, 8'h0A, 8'h59, 8'h5A});
    get_rsp(what, 2'h0);
    check({what, " tx count"}, ntx, 8'(tx_q.size()));
    if (ntx > 0) check({what, " tx char"}, 8'h58, tx_q[0]);
  endtask
  // ************************************************************
  // Test sequence.
  // ************************************************************
  initial begin
    {sys_rst, cfg_pad_en, slow, cyc_open, change_of_state_connection, rx_valid, rx_parity_err} = 7'h40;
    {cfg_tx_size, cfg_rx_size, cfg_tx_delim, cfg_rx_delim, cfg_pad_char, rx_char} = 48'h04060A0D2A00;
    expected_packet_rate = SGIO_RATE_ZERO;
    cfg_ext_baud = SGIO_BAUD_AUTO;
    net_baud_detect = 2'h1;
    {tx_ready, cfg_std_baud} = 3'h0;
    repeat (5) @(negedge clk_sys);
    check("baud reset", {6'h0, SGIO_BAUD_AUTO}, {6'h0, baud_sel});
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check("baud auto", 8'h01, {6'h0, baud_sel});
    @(posedge clk_sys);
    cfg_ext_baud <= 2'h2;
    cfg_std_baud <= 2'h2;
    repeat (3) @(negedge clk_sys);
    check("baud fixed", 8'h02, {6'h0, baud_sel});
    @(posedge clk_sys);
    cfg_std_baud <= SGIO_BAUD_AUTO;
    repeat (3) @(negedge clk_sys);
    check("baud std auto", 8'h02, {6'h0, baud_sel});
    // First poll with the transmitter stalled: characters wait in the FIFO and the answer waits for them.
    exp = {SGIO_REC_INIT, 8'h00, 8'h00};
    tx_q.delete();
    sgio_master_i.send_cmd({8'h01, 8'h03, 8'h58, 8'h0A, 8'h59, 8'h5A});
    repeat (20) @(negedge clk_sys);
    check("fifo fill", 8'h01, {7'h0, tx_valid});
    check("rsp held", 8'h00, 8'(sgio_master_i.frames));
    @(posedge clk_sys);
    tx_ready <= 1'b1;
    get_rsp("poll first", 2'h0);
    check("fifo drain", 8'h03, 8'(tx_q.size()));
    check("fifo data", 8'h58, tx_q[0]);
    check("fifo data", 8'h0A, tx_q[1]);
    check("fifo data", 8'h59, tx_q[2]);
    poll(8'h01, 8'h03, 8'h00, "poll repeat");
    cfg_pad_en <= 1'b1;
    rx_send(8'h41, 1'b0);
    rx_send(8'h42, 1'b0);
    rx_send(8'h0D, 1'b0);
    exp = {SGIO_REC_FIRST, 8'h00, 8'h03, 8'h41, 8'h42, 8'h0D, 8'h2A, 8'h2A, 8'h2A};
    poll(8'h02, 8'h00, 8'h02, "poll delim");
    check("delim tx", cfg_tx_delim, tx_q[1]);
    for (int i = 0; i < 6; i++) rx_send(8'(8'h61 + i), i == 2);
    exp = {8'h02, 8'h03, 8'h06, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66};
    poll(8'h03, 8'h01, 8'h01, "poll overflow");
    sgio_master_i.send_cmd({8'h03, 8'h01, 8'h58});
    repeat (3) @(negedge clk_sys);
    check("size error", 8'h01, {7'h0, cmd_size_err});
    repeat (40) @(posedge clk_sys);
    repeat (254) rx_send(8'h0D, 1'b0);
    exp = {SGIO_REC_FIRST, 8'h02, 8'h01, 8'h0D, 8'h2A, 8'h2A, 8'h2A, 8'h2A, 8'h2A};
    poll(8'h04, 8'h01, 8'h01, "poll wrap");
    check("size ok", 8'h00, {7'h0, cmd_size_err});
    @(posedge clk_sys);
    cfg_pad_en <= 1'b0;
    cyc_open <= 1'b1;
    @(posedge clk_sys);
    expected_packet_rate <= 16'h0002;
    exp = {SGIO_REC_FIRST, 8'h02, 8'h01, 8'h0D};
    tx_q.delete();
    get_rsp("cyclic", 2'h1);
    t0 = cyc;
    get_rsp("cyclic next", 2'h1);
    check("cyclic period", 8'(2 * TICK), 8'(cyc - t0));
    @(posedge clk_sys);
    slow <= 1'b1;
    get_rsp("cyclic slow", 2'h1);
    check("cyclic tx", 8'h00, 8'(tx_q.size()));
    check("timeout", 8'h01, {7'h0, conn_timeout});
    @(posedge clk_sys);
    change_of_state_connection <= 1'b1;
    repeat (3) @(negedge clk_sys);
    check("refused", 8'h01, {7'h0, conn_refused});
    @(posedge clk_sys);
    cyc_open <= 1'b0;
    expected_packet_rate <= SGIO_RATE_ZERO;
    repeat (30) @(negedge clk_sys);
    check("refused off", 8'h00, {7'h0, conn_refused});
    rx_send(8'h51, 1'b0);
    rx_send(8'h0D, 1'b0);
    exp = {8'h02, 8'h02, 8'h02, 8'h51, 8'h0D};
    get_rsp("change of state", 2'h2);
    print_verdict();
  end
endmodule

/* test/sgio_master.sv */
/*
  Fieldbus master model: starts polled commands and collects response frames.
  Assumes the handler's command and response ports, all on clk_sys.
*/
module sgio_master (
  input wire logic clk_sys,
  input wire logic slow,
  output logic cmd_valid,
  output logic cmd_first,
  output logic cmd_last,
  output logic [7:0] cmd_byte,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic [7:0] rsp_byte,
  input wire logic [1:0] rsp_conn,
  output logic rsp_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rsp_q[$]; // Bytes of the latest frame.
  logic [1:0] conn_q = 2'h0; // Connection type of the latest frame.
  logic open_q = 1'b0; // A frame is being collected.
  int frames = 0; // Complete frames seen.
  initial begin
    {cmd_valid, cmd_first, cmd_last, cmd_byte} = 11'h000;
    rsp_ready = 1'b1;
  end
  // Collect response bytes; a slow master drops ready every other cycle.
  always @(posedge clk_sys) begin
    if (rsp_valid && rsp_ready) begin
      if (!open_q) rsp_q.delete();
      rsp_q.push_back(rsp_byte);
      open_q = !rsp_last;
      if (rsp_last) begin
        conn_q = rsp_conn;
        frames++;
      end
    end
    rsp_ready <= slow ? !rsp_ready : 1'b1;
  end
  // Sends record, length and characters; timed connections get no bytes.
  task automatic send_cmd(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_first <= (i == 0);
      cmd_last <= (i == b.size() - 1);
      cmd_byte <= b[i];
    end
    @(posedge clk_sys);
    {cmd_valid, cmd_first, cmd_last} <= 3'h0;
    cmd_byte <= ~cmd_byte; // Released byte lane never shows stale data.
  endtask
endmodule
